// ==== hdl/prbt_ber_test.sv ====
/*
 * PRBS bit error rate test logic for the local (port 0) and backplane
 * (port 1) serial ports, with APB register access and one interrupt.
 * Assumes stream bits and bit ticks come from same-clock port logic.
 */
// The APB interface to the registers is this design's own decision.
`timescale 1ns/1ns

// Operation
// RULE1: Each port's transmitter and receiver enable independently of all others.
// RULE2: Read-only lock flag sets on lock, clears on receiver start rise.
// RULE3: Reseed rising edge loads the port's generator with the seed.
// RULE4: Clear rising edge zeroes the port's error counter and register.
// RULE5: Receiver start rising edge enables receiver hunting for the seed.
// RULE6: After seed, flag lock, compare every bit, count each mismatch.
// RULE7: Receiver start low disables comparison; error count holds, stays readable.
// RULE8: Transmitter start rising edge begins sending; low keeps transmission off.
// RULE9: Sequence select high picks 2^23-1, low picks 2^15-1.
// RULE10: Bits 15 to 12 reserved; all fields reset to zero.
// RULE11: Reference generator uses the transmitter's length and seed.
module prbt_ber_test #(
	parameter logic [22:0] SEED      = 23'h7fffff,
	parameter int unsigned CNT_WIDTH = 16
) (
	input  wire logic                                        pclk,
	input  wire logic                                        presetn,
	input  wire logic                                        psel,
	input  wire logic                                        penable,
	input  wire logic                                        pwrite,
	input  wire logic [7:0]                                  paddr,
	input  wire logic [31:0]                                 pwdata,
	output logic      [31:0]                                 prdata,
	output logic                                             pready,
	output logic                                             pslverr,
	input  wire prbt_pkg::prbt_stream_in_t  [prbt_pkg::NUM_PORTS-1:0] stream_in,
	output prbt_pkg::prbt_stream_out_t      [prbt_pkg::NUM_PORTS-1:0] stream_out,
	output logic                                             irq
);
	logic [15:0]          ctrl_reg;
	logic [15:0]          ctrl_prev_reg;
	logic [3:0]           irq_stat_reg;
	logic [3:0]           irq_mask_reg;
	logic [3:0]           irq_set;
	logic [1:0]           locked;
	logic [CNT_WIDTH-1:0] count_reg [prbt_pkg::NUM_PORTS];
	logic                 wr_en;
	logic                 rd_setup;
	logic                 mapped;
	logic [31:0]          rd_next;

	// Next state of a Fibonacci PRBS register for either length
	function automatic logic [22:0] prbs_step(input logic [22:0] s, input logic long_sel);
		logic fb;
		fb = 1'b0;
		if (long_sel) begin
			fb = s[prbt_pkg::LEN_LONG-1] ^ s[prbt_pkg::TAP_LONG-1];
		end else begin
			fb = s[prbt_pkg::LEN_SHORT-1] ^ s[prbt_pkg::TAP_SHORT-1];
		end
		prbs_step = {s[21:0], fb};
	endfunction : prbs_step

	// Oldest bit of the window, which is the next bit sent
	function automatic logic prbs_msb(input logic [22:0] s, input logic long_sel);
		prbs_msb = long_sel ? s[prbt_pkg::LEN_LONG-1] : s[prbt_pkg::LEN_SHORT-1];
	endfunction : prbs_msb

	// Window matches the seed over the selected length
	function automatic logic seed_hit(input logic [22:0] s, input logic long_sel);
		if (long_sel) begin
			seed_hit = (s == SEED);
		end else begin
			seed_hit = (s[14:0] == SEED[14:0]);
		end
	endfunction : seed_hit

	// Zero-wait slave: setup cycle raises pready, access edge completes
	assign rd_setup = psel & ~penable & ~pready;
	assign wr_en    = psel & penable & pready & pwrite & ~pslverr;
	assign mapped   = (paddr == prbt_pkg::ADDR_CTRL) | (paddr == prbt_pkg::ADDR_LP_COUNT) |
		(paddr == prbt_pkg::ADDR_BP_COUNT) | (paddr == prbt_pkg::ADDR_IRQ_STAT) |
		(paddr == prbt_pkg::ADDR_IRQ_MASK);

	// Read mux; reserved bits read as zero
	always_comb begin
		rd_next = 32'h0000_0000;
		case (paddr)
			prbt_pkg::ADDR_CTRL: begin
				rd_next[15:0] = ctrl_reg;
				rd_next[prbt_pkg::F_LOCKED] = locked[0];
				rd_next[prbt_pkg::PORT_STRIDE + prbt_pkg::F_LOCKED] = locked[1];
			end
			prbt_pkg::ADDR_LP_COUNT: rd_next[CNT_WIDTH-1:0] = count_reg[0];
			prbt_pkg::ADDR_BP_COUNT: rd_next[CNT_WIDTH-1:0] = count_reg[1];
			prbt_pkg::ADDR_IRQ_STAT: rd_next[3:0] = irq_stat_reg;
			prbt_pkg::ADDR_IRQ_MASK: rd_next[3:0] = irq_mask_reg;
			default: rd_next = 32'h0000_0000;
		endcase
	end

	// Bus answer registers, one cycle after setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= prbt_pkg::PRDATA_RESET;
		end else begin
			pready  <= rd_setup;
			pslverr <= rd_setup & ~mapped;
			if (rd_setup && !pwrite) begin
				prdata <= rd_next;
			end
		end
	end

	// RULE10 reset to zero
	// Control register; lock and reserved bits are not storable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg      <= prbt_pkg::CTRL_RESET;
			ctrl_prev_reg <= prbt_pkg::CTRL_RESET;
		end else begin
			ctrl_prev_reg <= ctrl_reg;
			if (wr_en && paddr == prbt_pkg::ADDR_CTRL) begin
				ctrl_reg <= pwdata[15:0] & prbt_pkg::CTRL_WMASK;
			end
		end
	end

	// Mask register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_reg <= prbt_pkg::IRQ_RESET;
		end else if (wr_en && paddr == prbt_pkg::ADDR_IRQ_MASK) begin
			irq_mask_reg <= pwdata[3:0];
		end
	end

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_reg <= prbt_pkg::IRQ_RESET;
			irq          <= 1'b0;
		end else begin
			if (wr_en && paddr == prbt_pkg::ADDR_IRQ_STAT) begin
				irq_stat_reg <= (irq_stat_reg & ~pwdata[3:0]) | irq_set;
			end else begin
				irq_stat_reg <= irq_stat_reg | irq_set;
			end
			irq <= |(irq_stat_reg & irq_mask_reg);
		end
	end

	// RULE1 per-port logic
	// Each port owns its own generator, checker and counter
	for (genvar p = 0; p < prbt_pkg::NUM_PORTS; p++) begin : g_port
		localparam int unsigned B = p * prbt_pkg::PORT_STRIDE;
		logic                    long_sel;
		logic                    tx_on;
		logic                    tick;
		logic                    rx_bit;
		logic                    tx_rise;
		logic                    rx_rise;
		logic                    clr_rise;
		logic                    seed_rise;
		logic                    pred;
		logic [22:0]             tx_lfsr_reg;
		logic [22:0]             rx_win_reg;
		logic [22:0]             ref_next;
		logic                    lock_reg;
		logic                    tx_active_reg;
		prbt_pkg::prbt_rx_state_t rx_state_reg;

		assign long_sel  = ctrl_reg[B + prbt_pkg::F_SEQ_LONG];
		assign tx_on     = ctrl_reg[B + prbt_pkg::F_TX_START];
		assign tick      = stream_in[p].bit_tick;
		assign rx_bit    = stream_in[p].rx_bit;
		assign tx_rise   = tx_on & ~ctrl_prev_reg[B + prbt_pkg::F_TX_START];
		assign rx_rise   = ctrl_reg[B + prbt_pkg::F_RX_START] &
			~ctrl_prev_reg[B + prbt_pkg::F_RX_START];
		assign clr_rise  = ctrl_reg[B + prbt_pkg::F_ERR_CLEAR] &
			~ctrl_prev_reg[B + prbt_pkg::F_ERR_CLEAR];
		assign seed_rise = ctrl_reg[B + prbt_pkg::F_RESEED] &
			~ctrl_prev_reg[B + prbt_pkg::F_RESEED];
		// RULE11 same length
		// Reference bit is the feedback of the window: the window holds the
		// last bits in line order, so its next state ends in the bit due next
		assign ref_next  = prbs_step(rx_win_reg, long_sel);
		assign pred      = ref_next[0];
		assign locked[p] = lock_reg;

		// RULE8 start and stop
		// Transmission runs from the rising edge while the bit stays high
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tx_active_reg <= 1'b0;
			end else if (!tx_on) begin
				tx_active_reg <= 1'b0;
			end else if (tx_rise) begin
				tx_active_reg <= 1'b1;
			end
		end

		// RULE3 reseed generator
		// RULE9 length select
		// Shifting out the seed first lets the far receiver lock on it
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				tx_lfsr_reg <= SEED;
			end else if (seed_rise) begin
				tx_lfsr_reg <= SEED;
			end else if (tick && tx_active_reg) begin
				tx_lfsr_reg <= prbs_step(tx_lfsr_reg, long_sel);
			end
		end

		// Serial output, held between ticks
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				stream_out[p] <= '0;
			end else if (tick) begin
				stream_out[p].tx_en  <= tx_active_reg;
				stream_out[p].tx_bit <= tx_active_reg & prbs_msb(tx_lfsr_reg, long_sel);
			end
		end

		// RULE5 receiver start
		// RULE7 comparison off when low
		// Receiver state: hunt for the seed, then track
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rx_state_reg <= prbt_pkg::RX_OFF;
			end else if (!ctrl_reg[B + prbt_pkg::F_RX_START]) begin
				rx_state_reg <= prbt_pkg::RX_OFF;
			end else begin
				case (rx_state_reg)
					prbt_pkg::RX_OFF: begin
						if (rx_rise) begin
							rx_state_reg <= prbt_pkg::RX_HUNT;
						end
					end
					prbt_pkg::RX_HUNT: begin
						if (seed_hit(rx_win_reg, long_sel)) begin
							rx_state_reg <= prbt_pkg::RX_LOCK;
						end
					end
					prbt_pkg::RX_LOCK: rx_state_reg <= prbt_pkg::RX_LOCK;
					default: rx_state_reg <= prbt_pkg::RX_OFF;
				endcase
			end
		end

		// RULE11 same seed and taps
		// Window takes line bits while hunting, predicted bits once locked,
		// so a single line error is counted once, not fed back
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				rx_win_reg <= '0;
			end else if (rx_rise) begin
				rx_win_reg <= '0;
			end else if (tick && rx_state_reg == prbt_pkg::RX_HUNT) begin
				rx_win_reg <= {rx_win_reg[21:0], rx_bit};
			end else if (tick && rx_state_reg == prbt_pkg::RX_LOCK) begin
				rx_win_reg <= ref_next;
			end
		end

		// RULE2 lock flag
		// Lock holds after the receiver stops, clears on a new start
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				lock_reg <= 1'b0;
			end else if (rx_rise) begin
				lock_reg <= 1'b0;
			end else if (rx_state_reg == prbt_pkg::RX_HUNT &&
				seed_hit(rx_win_reg, long_sel) && ctrl_reg[B + prbt_pkg::F_RX_START]) begin
				lock_reg <= 1'b1;
			end
		end

		// RULE4 clear count
		// RULE6 count mismatches
		// Saturates rather than wrapping so a bad link never reads low
		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				count_reg[p] <= '0;
			end else if (clr_rise) begin
				count_reg[p] <= '0;
			end else if (tick && rx_state_reg == prbt_pkg::RX_LOCK &&
				ctrl_reg[B + prbt_pkg::F_RX_START] && rx_bit != pred &&
				count_reg[p] != {CNT_WIDTH{1'b1}}) begin
				count_reg[p] <= count_reg[p] + 1'b1;
			end
		end

		// Interrupt events: lock gained, bit error seen
		assign irq_set[prbt_pkg::IRQ_LOCK_BASE + p] = ~lock_reg & ~rx_rise &
			rx_state_reg == prbt_pkg::RX_HUNT & seed_hit(rx_win_reg, long_sel) &
			ctrl_reg[B + prbt_pkg::F_RX_START];
		assign irq_set[prbt_pkg::IRQ_ERR_BASE + p] = tick & ~clr_rise &
			rx_state_reg == prbt_pkg::RX_LOCK & ctrl_reg[B + prbt_pkg::F_RX_START] &
			(rx_bit != pred);
	end
endmodule : prbt_ber_test

// ==== hdl/prbt_pkg.sv ====
/*
 * Shared constants and types for the PRBS bit error rate test block.
 * Assumes a 32-bit APB with byte addresses and the serial-port timing
 * logic on the same pclk domain.
 */
package prbt_pkg;
	// Control register index, byte address is four times it
	localparam int unsigned CTRL_IDX       = 2;
	localparam logic [7:0]  ADDR_CTRL      = 8'(CTRL_IDX * 4);
	localparam logic [7:0]  ADDR_LP_COUNT  = 8'h10;
	localparam logic [7:0]  ADDR_BP_COUNT  = 8'h14;
	localparam logic [7:0]  ADDR_IRQ_STAT  = 8'h18;
	localparam logic [7:0]  ADDR_IRQ_MASK  = 8'h1c;
	// Field offsets inside one port's six-bit group
	localparam int unsigned F_SEQ_LONG     = 0;
	localparam int unsigned F_TX_START     = 1;
	localparam int unsigned F_RX_START     = 2;
	localparam int unsigned F_ERR_CLEAR    = 3;
	localparam int unsigned F_RESEED       = 4;
	localparam int unsigned F_LOCKED       = 5;
	localparam int unsigned PORT_STRIDE    = 6;
	localparam int unsigned NUM_PORTS      = 2;
	localparam logic [15:0] CTRL_RESET     = 16'h0000;
	localparam logic [15:0] CTRL_WMASK     = 16'h07df;
	// Interrupt status layout
	localparam int unsigned IRQ_LOCK_BASE  = 0;
	localparam int unsigned IRQ_ERR_BASE   = 2;
	localparam logic [3:0]  IRQ_RESET      = 4'h0;
	// Sequence lengths and feedback taps
	localparam int unsigned LEN_SHORT      = 15;
	localparam int unsigned TAP_SHORT      = 14;
	localparam int unsigned LEN_LONG       = 23;
	localparam int unsigned TAP_LONG       = 18;
	localparam logic [31:0] PRDATA_RESET   = 32'h0000_0000;

	typedef struct packed {
		logic bit_tick;
		logic rx_bit;
	} prbt_stream_in_t;

	typedef struct packed {
		logic tx_bit;
		logic tx_en;
	} prbt_stream_out_t;

	typedef enum logic [1:0] {
		RX_OFF  = 2'b00,
		RX_HUNT = 2'b01,
		RX_LOCK = 2'b11
	} prbt_rx_state_t;
endpackage : prbt_pkg

// ==== verification/prbs_ber_test_control_bench.sv ====
/* Self-checking bench for the BER test block with a loopback peer.
   Assumes package, design, peer and checker compile first. */
`timescale 1ns/1ns
module prbs_ber_test_control_bench;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite, slv;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, q;
	logic        pready, pslverr, irq;
	logic [1:0]  flip;
	int          bad_count = 0;
	int          n_tests = 0;
	prbt_pkg::prbt_stream_in_t [prbt_pkg::NUM_PORTS-1:0]  si;
	prbt_pkg::prbt_stream_out_t [prbt_pkg::NUM_PORTS-1:0] so;
	// 125 MHz clock
	always #4 pclk = ~pclk;
	prbt_ber_test #(.SEED(23'h7fffff)) dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .stream_in(si), .stream_out(so), .irq(irq));
	prbt_peer peer_u (.pclk(pclk), .presetn(presetn), .flip(flip), .so(so), .si(si));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	// One APB transfer; never assumes how fast pready comes
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		chk("pready", {31'h0, pready}, 32'h1);
		q = prdata;
		slv = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, q, e);
	endtask : rd
	// Flip exactly k received bits of port p, starting after a tick
	task automatic inject(input int p, input int k);
		@(posedge pclk iff si[0].bit_tick);
		flip[p] <= 1'b1;
		repeat (4 * k) @(posedge pclk);
		flip[p] <= 1'b0;
	endtask : inject
	// Count ones sent by port p over k ticks
	task automatic ones(input int p, input int k, output int n);
		n = 0;
		repeat (k) begin
			@(posedge pclk iff si[0].bit_tick);
			#1 n += so[p].tx_bit;
		end
	endtask : ones
	task automatic t_reset;
		rd("ctrl", prbt_pkg::ADDR_CTRL, 32'h0);
		rd("irq stat", prbt_pkg::ADDR_IRQ_STAT, 32'h0);
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'hf820);
		rd("ctrl ro", prbt_pkg::ADDR_CTRL, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk("slverr", {31'h0, slv}, 32'h1);
	endtask : t_reset
	task automatic t_lp_lock;
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'h6);
		repeat (160) @(posedge pclk);
		rd("lp lock", prbt_pkg::ADDR_CTRL, 32'h26);
		rd("lp clean", prbt_pkg::ADDR_LP_COUNT, 32'h0);
		inject(0, 3);
		rd("lp errs", prbt_pkg::ADDR_LP_COUNT, 32'h3);
	endtask : t_lp_lock
	// frozen count, then clear and relaunch
	task automatic t_freeze;
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'h2);
		inject(0, 2);
		rd("lp frozen", prbt_pkg::ADDR_LP_COUNT, 32'h3);
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'ha);
		rd("lp cleared", prbt_pkg::ADDR_LP_COUNT, 32'h0);
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'he);
		rd("lock drop", prbt_pkg::ADDR_CTRL, 32'he);
	endtask : t_freeze
	// reseed restarts the all-ones seed run, long mode runs longer
	// The transmitter is stopped first so a low line bit precedes the seed
	task automatic t_seed;
		int n;
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'hc);
		repeat (8) @(posedge pclk);
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'h1e);
		ones(0, 15, n);
		chk("lp seed run", {31'h0, n >= 13}, 32'h1);
		apb(1'b1, prbt_pkg::ADDR_CTRL, 32'h1de);
		ones(1, 23, n);
		chk("bp long run", {31'h0, n >= 21}, 32'h1);
		repeat (160) @(posedge pclk);
		rd("both locked", prbt_pkg::ADDR_CTRL, 32'h9fe);
		rd("bp clean", prbt_pkg::ADDR_BP_COUNT, 32'h0);
		inject(1, 1);
		rd("bp errs", prbt_pkg::ADDR_BP_COUNT, 32'h1);
	endtask : t_seed
	task automatic t_irq;
		chk("irq masked", {31'h0, irq}, 32'h0);
		apb(1'b1, prbt_pkg::ADDR_IRQ_MASK, 32'h8);
		rd("irq all", prbt_pkg::ADDR_IRQ_STAT, 32'hf);
		chk("irq on", {31'h0, irq}, 32'h1);
		apb(1'b1, prbt_pkg::ADDR_IRQ_STAT, 32'h8);
		rd("irq w1c", prbt_pkg::ADDR_IRQ_STAT, 32'h7);
		chk("irq off", {31'h0, irq}, 32'h0);
	endtask : t_irq
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : report_and_stop
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, flip} = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_lp_lock;
		t_freeze;
		t_seed;
		t_irq;
		report_and_stop;
	end
	// Run needs about 600 cycles; a hang ends here
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		report_and_stop;
	end
endmodule : prbs_ber_test_control_bench

// ==== verification/prbt_checker.sv ====
/* Port checker for the BER test block.
   Assumes it is bound to prbt_ber_test, one clock. */
`timescale 1ns/1ns
module prbt_checker (
	input wire logic                                          pclk,
	input wire logic                                          presetn,
	input wire logic                                          psel,
	input wire logic                                          penable,
	input wire logic                                          pwrite,
	input wire logic [7:0]                                    paddr,
	input wire logic [31:0]                                   pwdata,
	input wire logic [31:0]                                   prdata,
	input wire logic                                          pready,
	input wire logic                                          pslverr,
	input wire prbt_pkg::prbt_stream_in_t [prbt_pkg::NUM_PORTS-1:0]  stream_in,
	input wire prbt_pkg::prbt_stream_out_t [prbt_pkg::NUM_PORTS-1:0] stream_out,
	input wire logic                                          irq
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Bus answers one cycle after setup, for one cycle
	a_ready_next: assert property (psel && !penable |=> pready) else $error("late pready");
	a_ready_pulse: assert property (pready |=> !pready) else $error("pready too long");
	a_err_ready: assert property (pslverr |-> pready) else $error("stray pslverr");
	a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
		else $error("error read not zero");
	a_ctrl_resv: assert property (pready && !pwrite && paddr == prbt_pkg::ADDR_CTRL
		|-> prdata[31:12] == 20'h0) else $error("reserved control bits set");
	// Idle transmitter sends zeros
	a_tx_quiet: assert property ((stream_out[0].tx_en || !stream_out[0].tx_bit)
		&& (stream_out[1].tx_en || !stream_out[1].tx_bit)) else $error("tx bit while off");
	// Outputs move only at a bit tick; a slip shows as a change without one
	a_tx_tick_lp: assert property ($changed(stream_out[0]) |-> $past(stream_in[0].bit_tick))
		else $error("local tx moved off tick");
	a_tx_tick_bp: assert property ($changed(stream_out[1]) |-> $past(stream_in[1].bit_tick))
		else $error("backplane tx moved off tick");
	a_reset_quiet: assert property (disable iff (1'b0) !presetn
		|-> !irq && !pready && stream_out == '0) else $error("output active in reset");
	c_refused: cover property (pready && pslverr);
	c_bp_tx: cover property (stream_out[1].tx_en);
	c_irq: cover property ($rose(irq));
endmodule : prbt_checker

bind prbt_ber_test prbt_checker chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .stream_in(stream_in), .stream_out(stream_out),
	.irq(irq));

// ==== verification/prbt_peer.sv ====
/* Far-side stream peer: ticks both ports, loops tx back to rx.
   Assumes the design samples rx bits on pclk edges with a tick. */
`timescale 1ns/1ns
module prbt_peer (
	input wire logic                                          pclk,
	input wire logic                                          presetn,
	input wire logic [1:0]                                    flip,
	input wire prbt_pkg::prbt_stream_out_t [prbt_pkg::NUM_PORTS-1:0] so,
	output wire prbt_pkg::prbt_stream_in_t [prbt_pkg::NUM_PORTS-1:0] si
);
	logic [1:0] div;
	// Tick every fourth cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div <= 2'h0;
		end else begin
			div <= div + 2'h1;
		end
	end
	// each port looped alone
	// A stopped transmitter leaves the line low, the inverse of the all-ones
	// seed, so a receiver cannot lock on a dead line or one bit early
	for (genvar p = 0; p < 2; p++) begin : g_port
		assign si[p].bit_tick = (div == 2'h3);
		assign si[p].rx_bit   = so[p].tx_en ? (so[p].tx_bit ^ flip[p]) : 1'b0;
	end
endmodule : prbt_peer
